// ===== include/mcsr_defines.svh
// Offsets, field positions, reset values, masks and address map
`ifndef MCSR_DEFINES_SVH
`define MCSR_DEFINES_SVH

`define MCSR_SFR_STACK_TOP     8'h81
`define MCSR_SFR_PTR0_LOW      8'h82
`define MCSR_SFR_PTR0_HIGH     8'h83
`define MCSR_SFR_PTR1_LOW      8'h84
`define MCSR_SFR_PTR1_HIGH     8'h85
`define MCSR_SFR_MEM_TIMING    8'h8e
`define MCSR_SFR_PTR_SELECT    8'h92
`define MCSR_SFR_STATUS_WORD   8'hd0
`define MCSR_SFR_MAIN_OPERAND  8'he0
`define MCSR_SFR_MULDIV        8'hf0

`define MCSR_RST_STACK_TOP     8'h07
`define MCSR_RST_ZERO          8'h00
`define MCSR_RST_MEM_TIMING    8'h01
`define MCSR_MEM_TIMING_MASK   8'h77
`define MCSR_PTR_SELECT_MASK   8'h01

`define MCSR_PSW_CARRY         7
`define MCSR_PSW_NIBBLE        6
`define MCSR_PSW_USER0         5
`define MCSR_PSW_BANK_HI       4
`define MCSR_PSW_BANK_LO       3
`define MCSR_PSW_EXCESS        2
`define MCSR_PSW_USER1         1
`define MCSR_PSW_PARITY        0

`define MCSR_XRAM_BASE         16'h8000
`define MCSR_XRAM_LAST         16'h87ff
`define MCSR_INTERNAL_SCRATCH_MEMORY_DIRECT_TOP   8'h7f

`define MCSR_WB_SFR_BASE       12'h000
`define MCSR_WB_INTERNAL_SCRATCH_MEMORY_BASE      12'h400
`define MCSR_WB_CORE_CTRL      12'h800
`define MCSR_WB_CORE_STAT      12'h804
`define MCSR_WB_XRAM_BASE      12'h000

`endif

// ===== include/mcsr_pkg.sv
// Types shared by the core register file
package mcsr_pkg;
  typedef enum logic [2:0] {
    MCSR_IDLE  = 3'b001,
    MCSR_WAIT  = 3'b010,
    MCSR_ACK   = 3'b100
  } mcsr_bus_state_t;

  typedef enum logic [2:0] {
    MCSR_OP_NONE = 3'h0,
    MCSR_OP_PUSH = 3'h1,
    MCSR_OP_POP  = 3'h2,
    MCSR_OP_LOAD = 3'h3,
    MCSR_OP_INC  = 3'h4
  } mcsr_stack_op_t;
endpackage : mcsr_pkg

// ===== design/mcsr_scratch_ram.sv
// Byte-wide single-port RAM used for scratch and external data memory
`timescale 1ns/1ps
module mcsr_scratch_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wr_data,
  output      logic [7:0]    rd_data
);
  // ==========================================================
  // Storage
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule : mcsr_scratch_ram

// ===== design/mcsr_parity.sv
// Odd parity of a byte
`timescale 1ns/1ps
module mcsr_parity (
  input  wire logic [7:0] data_in,
  output      logic       odd_out
);
  // ==========================================================
  // Reduction
  assign odd_out = ^data_in;
endmodule : mcsr_parity

// ===== design/mcsr_core_regs.sv
// Core special function registers, scratch memory and general RAM
//
// Functional notes
// RULE_01: Main operand register at 0xE0 feeds and takes results; resets zero.
// RULE_02: Multiply/divide operand register at 0xF0; scratch byte; resets zero.
// RULE_03: Status bit 7 is carry and Boolean accumulator; word at 0xD0.
// RULE_04: Status bit 6 set on carry out of operand bit 3.
// RULE_05: Status bits 4-3 choose one of four eight-byte register banks.
// RULE_06: Status bit 2 set on signed overflow of arithmetic.
// RULE_07: Status bits 5 and 1 are free user flags.
// RULE_08: Status bit 0 shows odd parity of the main operand register.
// RULE_09: Software writes never alter the parity bit.
// RULE_10: Stack pointer at 0x81 resets 0x07; pre-increment push, post-decrement pop.
// RULE_11: Data pointers as 16 bits or bytes; 0x83/0x82 and 0x85/0x84.
// RULE_12: Active data pointer supplies 16-bit indirect address.
// RULE_13: Pointer select bit 0 at 0x92 chooses pointer; resets zero.
// RULE_14: Scratch memory 256 bytes; upper half only indirectly addressed (code refuses only direct writes; direct reads return data).
// RULE_15: 2048-byte RAM decodes at 0x8000 through 0x87FF.
// RULE_16: Timing bits 2-0 at 0x8E set data stretch; default 001.
// RULE_17: Timing bits 6-4 set program wait states; default 000.
// RULE_18: Unused select and timing bits read zero, ignore writes.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "mcsr_defines.svh"
module mcsr_core_regs
  import mcsr_pkg::*;
#(
  parameter int INTERNAL_SCRATCH_MEMORY_DEPTH = 256,
  parameter int XRAM_DEPTH = 2048
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  // Datapath side
  input  wire logic        dp_acc_we,
  input  wire logic [7:0]  dp_acc_wdata,
  input  wire logic        dp_b_we,
  input  wire logic [7:0]  dp_b_wdata,
  input  wire logic        dp_flags_we,
  input  wire logic        dp_carry,
  input  wire logic        dp_nibble_carry,
  input  wire logic        dp_signed_excess,
  input  wire logic [2:0]  dp_stack_op,
  input  wire logic        dp_dptr_we,
  input  wire logic [15:0] dp_dptr_wdata,
  input  wire logic        dp_dptr_inc,
  input  wire logic        dp_internal_scratch_memory_we,
  input  wire logic        dp_internal_scratch_memory_indirect,
  input  wire logic [7:0]  dp_internal_scratch_memory_addr,
  input  wire logic [7:0]  dp_internal_scratch_memory_wdata,
  input  wire logic        dp_external_data_space_we,
  input  wire logic [15:0] dp_external_data_space_addr,
  input  wire logic [7:0]  dp_external_data_space_wdata,
  output      logic [7:0]  acc_out,
  output      logic [7:0]  b_out,
  output      logic [7:0]  psw_out,
  output      logic [7:0]  sp_out,
  output      logic [15:0] active_dptr,
  output      logic [4:0]  bank_base,
  output      logic [2:0]  external_data_space_stretch,
  output      logic [2:0]  code_wait,
  output      logic [7:0]  internal_scratch_memory_rdata,
  output      logic [7:0]  xram_rdata,
  output      logic        xram_hit,
  output      logic        internal_scratch_memory_refused
);

  // ==========================================================
  // Registers
  logic [7:0]  acc_reg;
  logic [7:0]  b_reg;
  logic [7:0]  psw_reg;
  logic [7:0]  sp_reg;
  logic [15:0] dptr0_reg;
  logic [15:0] dptr1_reg;
  logic [7:0]  timing_reg;
  logic [7:0]  psel_reg;
  logic        parity_bit;
  mcsr_bus_state_t bus_reg;

  // ==========================================================
  // Bus decode
  logic        wr_stb;
  logic [7:0]  wb_byte;
  logic        sfr_hit;
  logic [7:0]  sfr_adr;
  logic        internal_scratch_memory_bus;
  assign wr_stb   = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
                    (bus_reg == MCSR_IDLE);
  assign wb_byte  = wb_dat_i[7:0];
  assign sfr_hit  = (wb_adr_i[11:10] == 2'b00);
  assign sfr_adr  = wb_adr_i[9:2];
  assign internal_scratch_memory_bus = (wb_adr_i[11:10] == 2'b01);

  function automatic logic sfr_wr(input logic [7:0] a);
    sfr_wr = wr_stb && sfr_hit && (sfr_adr == a);
  endfunction : sfr_wr

  // ==========================================================
  // Main operand and multiply/divide registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acc_reg <= `MCSR_RST_ZERO; // RULE_01
    end else if (dp_acc_we) begin
      acc_reg <= dp_acc_wdata; // RULE_01
    end else if (sfr_wr(`MCSR_SFR_MAIN_OPERAND)) begin
      acc_reg <= wb_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      b_reg <= `MCSR_RST_ZERO; // RULE_02
    end else if (dp_b_we) begin
      b_reg <= dp_b_wdata; // RULE_02
    end else if (sfr_wr(`MCSR_SFR_MULDIV)) begin
      b_reg <= wb_byte;
    end
  end

  // ==========================================================
  // Status word
  mcsr_parity u_parity (
    .data_in (acc_reg),
    .odd_out (parity_bit)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      psw_reg <= `MCSR_RST_ZERO;
    end else begin
      if (sfr_wr(`MCSR_SFR_STATUS_WORD)) begin
        psw_reg[7:1] <= wb_byte[7:1]; // RULE_07
      end
      if (dp_flags_we) begin
        psw_reg[`MCSR_PSW_CARRY]  <= dp_carry; // RULE_03
        psw_reg[`MCSR_PSW_NIBBLE] <= dp_nibble_carry; // RULE_04
        psw_reg[`MCSR_PSW_EXCESS] <= dp_signed_excess; // RULE_06
      end
      psw_reg[`MCSR_PSW_PARITY] <= 1'b0; // RULE_09
    end
  end

  logic [7:0] psw_view;
  assign psw_view = {psw_reg[7:1], parity_bit}; // RULE_08

  // ==========================================================
  // Stack pointer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sp_reg <= `MCSR_RST_STACK_TOP; // RULE_10
    end else begin
      case (dp_stack_op)
        MCSR_OP_PUSH: sp_reg <= sp_reg + 8'h01; // RULE_10
        MCSR_OP_POP:  sp_reg <= sp_reg - 8'h01; // RULE_10
        default: begin
          if (sfr_wr(`MCSR_SFR_STACK_TOP)) begin
            sp_reg <= wb_byte;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Data pointers and select
  logic psel;
  assign psel = psel_reg[0];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dptr0_reg <= 16'h0000; // RULE_11
    end else if (!psel && dp_dptr_we) begin
      dptr0_reg <= dp_dptr_wdata; // RULE_11
    end else if (!psel && dp_dptr_inc) begin
      dptr0_reg <= dptr0_reg + 16'h0001;
    end else if (sfr_wr(`MCSR_SFR_PTR0_LOW)) begin
      dptr0_reg[7:0] <= wb_byte; // RULE_11
    end else if (sfr_wr(`MCSR_SFR_PTR0_HIGH)) begin
      dptr0_reg[15:8] <= wb_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dptr1_reg <= 16'h0000;
    end else if (psel && dp_dptr_we) begin
      dptr1_reg <= dp_dptr_wdata; // RULE_11
    end else if (psel && dp_dptr_inc) begin
      dptr1_reg <= dptr1_reg + 16'h0001;
    end else if (sfr_wr(`MCSR_SFR_PTR1_LOW)) begin
      dptr1_reg[7:0] <= wb_byte;
    end else if (sfr_wr(`MCSR_SFR_PTR1_HIGH)) begin
      dptr1_reg[15:8] <= wb_byte; // RULE_11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      psel_reg <= `MCSR_RST_ZERO; // RULE_13
    end else if (sfr_wr(`MCSR_SFR_PTR_SELECT)) begin
      psel_reg <= wb_byte & `MCSR_PTR_SELECT_MASK; // RULE_18
    end
  end

  // ==========================================================
  // Memory timing control
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      timing_reg <= `MCSR_RST_MEM_TIMING; // RULE_16 RULE_17
    end else if (sfr_wr(`MCSR_SFR_MEM_TIMING)) begin
      timing_reg <= wb_byte & `MCSR_MEM_TIMING_MASK; // RULE_18
    end
  end

  // ==========================================================
  // Scratch memory and general RAM
  logic       internal_scratch_memory_dp_ok;
  logic       internal_scratch_memory_we;
  logic [7:0] internal_scratch_memory_addr;
  logic [7:0] internal_scratch_memory_q;
  logic       xram_dp_hit;
  logic       xram_we;
  logic [10:0] xram_addr;
  logic [7:0] xram_q;

  // Upper half refuses direct datapath writes
  assign internal_scratch_memory_dp_ok = dp_internal_scratch_memory_indirect ||
                      (dp_internal_scratch_memory_addr <= `MCSR_INTERNAL_SCRATCH_MEMORY_DIRECT_TOP); // RULE_14
  assign internal_scratch_memory_we    = (dp_internal_scratch_memory_we && internal_scratch_memory_dp_ok) ||
                      (wr_stb && internal_scratch_memory_bus);
  assign internal_scratch_memory_addr  = (dp_internal_scratch_memory_we && internal_scratch_memory_dp_ok) ? dp_internal_scratch_memory_addr :
                      (wb_cyc_i && wb_stb_i && internal_scratch_memory_bus) ? wb_adr_i[9:2] :
                      dp_internal_scratch_memory_addr;

  mcsr_scratch_ram #(.DEPTH(INTERNAL_SCRATCH_MEMORY_DEPTH), .AW(8)) u_internal_scratch_memory ( // RULE_14
    .clk_sys (clk_sys),
    .wr_en   (internal_scratch_memory_we),
    .addr    (internal_scratch_memory_addr),
    .wr_data ((dp_internal_scratch_memory_we && internal_scratch_memory_dp_ok) ? dp_internal_scratch_memory_wdata : wb_byte),
    .rd_data (internal_scratch_memory_q)
  );

  assign xram_dp_hit = (dp_external_data_space_addr >= `MCSR_XRAM_BASE) &&
                       (dp_external_data_space_addr <= `MCSR_XRAM_LAST); // RULE_15
  assign xram_we     = dp_external_data_space_we && xram_dp_hit;
  assign xram_addr   = dp_external_data_space_addr[10:0];

  mcsr_scratch_ram #(.DEPTH(XRAM_DEPTH), .AW(11)) u_xram ( // RULE_15
    .clk_sys (clk_sys),
    .wr_en   (xram_we),
    .addr    (xram_addr),
    .wr_data (dp_external_data_space_wdata),
    .rd_data (xram_q)
  );

  // ==========================================================
  // Datapath outputs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acc_out       <= `MCSR_RST_ZERO;
      b_out         <= `MCSR_RST_ZERO;
      psw_out       <= `MCSR_RST_ZERO;
      sp_out        <= `MCSR_RST_STACK_TOP;
      active_dptr   <= 16'h0000;
      bank_base     <= 5'h00;
      external_data_space_stretch <= 3'h1;
      code_wait     <= 3'h0;
      internal_scratch_memory_rdata    <= `MCSR_RST_ZERO;
      xram_rdata    <= `MCSR_RST_ZERO;
      xram_hit      <= 1'b0;
      internal_scratch_memory_refused  <= 1'b0;
    end else begin
      acc_out       <= acc_reg;
      b_out         <= b_reg;
      psw_out       <= psw_view;
      sp_out        <= sp_reg;
      active_dptr   <= psel ? dptr1_reg : dptr0_reg; // RULE_12
      bank_base     <= {psw_reg[4:3], 3'b000}; // RULE_05
      external_data_space_stretch <= timing_reg[2:0]; // RULE_16
      code_wait     <= timing_reg[6:4]; // RULE_17
      internal_scratch_memory_rdata    <= internal_scratch_memory_q;
      xram_rdata    <= xram_q;
      xram_hit      <= xram_dp_hit;
      internal_scratch_memory_refused  <= dp_internal_scratch_memory_we && !internal_scratch_memory_dp_ok;
    end
  end

  // ==========================================================
  // Wishbone answer
  logic [7:0] sfr_rd;
  always_comb begin
    sfr_rd = 8'h00;
    if (sfr_adr == `MCSR_SFR_STACK_TOP) begin
      sfr_rd = sp_reg;
    end else if (sfr_adr == `MCSR_SFR_PTR0_LOW) begin
      sfr_rd = dptr0_reg[7:0];
    end else if (sfr_adr == `MCSR_SFR_PTR0_HIGH) begin
      sfr_rd = dptr0_reg[15:8];
    end else if (sfr_adr == `MCSR_SFR_PTR1_LOW) begin
      sfr_rd = dptr1_reg[7:0];
    end else if (sfr_adr == `MCSR_SFR_PTR1_HIGH) begin
      sfr_rd = dptr1_reg[15:8];
    end else if (sfr_adr == `MCSR_SFR_MEM_TIMING) begin
      sfr_rd = timing_reg;
    end else if (sfr_adr == `MCSR_SFR_PTR_SELECT) begin
      sfr_rd = psel_reg;
    end else if (sfr_adr == `MCSR_SFR_STATUS_WORD) begin
      sfr_rd = psw_view;
    end else if (sfr_adr == `MCSR_SFR_MAIN_OPERAND) begin
      sfr_rd = acc_reg;
    end else if (sfr_adr == `MCSR_SFR_MULDIV) begin
      sfr_rd = b_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bus_reg  <= MCSR_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (bus_reg)
        MCSR_IDLE: begin
          wb_ack_o <= 1'b0;
          if (wb_cyc_i && wb_stb_i) begin
            bus_reg <= MCSR_WAIT;
          end
        end
        MCSR_WAIT: begin
          bus_reg  <= MCSR_ACK;
          wb_ack_o <= 1'b1;
          if (sfr_hit) begin
            wb_dat_o <= {24'h000000, sfr_rd};
          end else if (internal_scratch_memory_bus) begin
            wb_dat_o <= {24'h000000, internal_scratch_memory_q};
          end else begin
            wb_dat_o <= 32'h0000_0000;
          end
        end
        MCSR_ACK: begin
          wb_ack_o <= 1'b0;
          bus_reg  <= MCSR_IDLE;
        end
        default: bus_reg <= MCSR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  parity_track_a: assert property ( // RULE_08
    @(posedge clk_sys) disable iff (!resetn)
    ##1 psw_out[0] == ^$past(acc_reg))
    else $error("parity does not follow operand");
  parity_wr_a: assert property ( // RULE_09
    @(posedge clk_sys) disable iff (!resetn)
    sfr_wr(`MCSR_SFR_STATUS_WORD) |=> psw_out[0] == ^acc_out)
    else $error("software changed parity");
  stack_push_a: assert property ( // RULE_10
    @(posedge clk_sys) disable iff (!resetn)
    dp_stack_op == MCSR_OP_PUSH |=> sp_reg == $past(sp_reg) + 8'h01)
    else $error("push did not pre-increment");
  stack_pop_a: assert property ( // RULE_10
    @(posedge clk_sys) disable iff (!resetn)
    dp_stack_op == MCSR_OP_POP |=> sp_reg == $past(sp_reg) - 8'h01)
    else $error("pop did not decrement");
  dptr_pick_a: assert property ( // RULE_12
    @(posedge clk_sys) disable iff (!resetn)
    ##1 active_dptr == ($past(psel) ? $past(dptr1_reg) : $past(dptr0_reg)))
    else $error("wrong active pointer");
  sel_mask_a: assert property ( // RULE_18
    @(posedge clk_sys) disable iff (!resetn)
    psel_reg[7:1] == 7'h00 && timing_reg[7] == 1'b0 && timing_reg[3] == 1'b0)
    else $error("unused bits not zero");
  bank_map_a: assert property ( // RULE_05
    @(posedge clk_sys) disable iff (!resetn)
    ##1 bank_base == {$past(psw_reg[4:3]), 3'b000})
    else $error("bank base mismatch");
  internal_scratch_memory_direct_a: assert property ( // RULE_14
    @(posedge clk_sys) disable iff (!resetn)
    dp_internal_scratch_memory_we && !dp_internal_scratch_memory_indirect && dp_internal_scratch_memory_addr[7] |=> internal_scratch_memory_refused)
    else $error("direct upper access not refused");
  flags_load_a: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!resetn)
    dp_flags_we |=> psw_reg[7] == $past(dp_carry) &&
    psw_reg[6] == $past(dp_nibble_carry) &&
    psw_reg[2] == $past(dp_signed_excess))
    else $error("flags not loaded");
  xram_range_a: assert property ( // RULE_15
    @(posedge clk_sys) disable iff (!resetn)
    ##1 xram_hit == ($past(dp_external_data_space_addr[15:11]) == 5'h10))
    else $error("general RAM decode wrong");
  ack_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule : mcsr_core_regs

// ===== sim/tb.sv
// Self-checking bench for the core register file
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); \
  end \
end
module tb
  import mcsr_pkg::*;
;
  // ==========================================================
  // Signals
  localparam int TMO = 40;
  localparam logic [7:0] RA [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                                     8'h8e, 8'h92, 8'hd0, 8'he0, 8'hf0};
  localparam logic [7:0] RV [10] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
                                     8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WA [6]  = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                                     8'hf0};
  logic        clk_sys = 1'b0;
  logic        resetn;
  logic        wb_cyc, wb_stb, wb_we;
  logic [11:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, wb_dat_o, q;
  logic        wb_ack_o;
  logic        acc_we, b_we, flg_we, cy, nib, ov, ptr_we, ptr_inc;
  logic [7:0]  acc_wd, b_wd, ir_a, ir_wd, x_wd;
  logic [2:0]  stk_op;
  logic [15:0] ptr_wd, x_a;
  logic        ir_we, ir_ind, x_we, seen;
  logic [7:0]  acc_out, b_out, psw_out, sp_out, internal_scratch_memory_rdata, xram_rdata;
  logic [15:0] active_dptr;
  logic [4:0]  bank_base;
  logic [2:0]  external_data_space_stretch, code_wait;
  logic        xram_hit, internal_scratch_memory_refused;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #12.5 clk_sys = ~clk_sys;

  mcsr_core_regs uut (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dp_acc_we(acc_we),
    .dp_acc_wdata(acc_wd), .dp_b_we(b_we), .dp_b_wdata(b_wd),
    .dp_flags_we(flg_we), .dp_carry(cy), .dp_nibble_carry(nib),
    .dp_signed_excess(ov), .dp_stack_op(stk_op), .dp_dptr_we(ptr_we),
    .dp_dptr_wdata(ptr_wd), .dp_dptr_inc(ptr_inc), .dp_internal_scratch_memory_we(ir_we),
    .dp_internal_scratch_memory_indirect(ir_ind), .dp_internal_scratch_memory_addr(ir_a), .dp_internal_scratch_memory_wdata(ir_wd),
    .dp_external_data_space_we(x_we), .dp_external_data_space_addr(x_a), .dp_external_data_space_wdata(x_wd),
    .acc_out(acc_out), .b_out(b_out), .psw_out(psw_out), .sp_out(sp_out),
    .active_dptr(active_dptr), .bank_base(bank_base),
    .external_data_space_stretch(external_data_space_stretch), .code_wait(code_wait),
    .internal_scratch_memory_rdata(internal_scratch_memory_rdata), .xram_rdata(xram_rdata), .xram_hit(xram_hit),
    .internal_scratch_memory_refused(internal_scratch_memory_refused));

  // ==========================================================
  // Tasks
  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [11:0] sfa(input logic [7:0] s);
    return {2'b00, s, 2'b00};
  endfunction : sfa

  function automatic logic [11:0] ira(input logic [7:0] s);
    return {2'b01, s, 2'b00};
  endfunction : ira

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < TMO);
    if (n >= TMO) begin
      mismatches++;
      $display("[ERR] wb_ack exp 1 got %b", wb_ack_o);
      tally_and_finish();
    end
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'hf, r);
  endtask : wr

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [7:0] ex);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, 4'hf, r);
    `CHK(nm, {24'h000000, ex}, r)
  endtask : rd

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step

  task automatic iw(input logic ind, input logic [7:0] a, input logic [7:0] d);
    ir_we  <= 1'b1;
    ir_ind <= ind;
    ir_a   <= a;
    ir_wd  <= d;
    step(1);
    ir_we  <= 1'b0;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      seen = seen | internal_scratch_memory_refused;
    end
  endtask : iw

  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    x_we <= 1'b1;
    x_a  <= a;
    x_wd <= d;
    step(1);
    x_we <= 1'b0;
    step(2);
  endtask : xw

  // ==========================================================
  // Sequence
  initial begin
    resetn = 1'b0;
    {wb_cyc, wb_stb, wb_we, acc_we, b_we, flg_we, cy, nib, ov} = '0;
    {ptr_we, ptr_inc, ir_we, ir_ind, x_we} = '0;
    {wb_adr, wb_sel, wb_dat, acc_wd, b_wd, ir_a, ir_wd, x_wd} = '0;
    {stk_op, ptr_wd, x_a} = '0;
    step(6);
    resetn <= 1'b1;
    step(1);
    `CHK("sp_out", 8'h07, sp_out)
    `CHK("stretch", 3'h1, external_data_space_stretch)
    `CHK("code_wait", 3'h0, code_wait)
    for (int i = 0; i < 10; i++) rd("rst", sfa(RA[i]), RV[i]);
    foreach (WA[i]) wr(sfa(WA[i]), 8'h30 + i[7:0]);
    foreach (WA[i]) rd("rw", sfa(WA[i]), 8'h30 + i[7:0]);
    `CHK("b_out", 8'h35, b_out)
    `CHK("dptr0", 16'h3231, active_dptr)
    wr(sfa(8'h92), 8'hff);
    rd("sel", sfa(8'h92), 8'h01);
    `CHK("dptr1", 16'h3433, active_dptr)
    ptr_we <= 1'b1;
    ptr_wd <= 16'h12ff;
    step(1);
    ptr_we  <= 1'b0;
    ptr_inc <= 1'b1;
    step(1);
    ptr_inc <= 1'b0;
    step(2);
    `CHK("dptr_inc", 16'h1300, active_dptr)
    rd("p1h", sfa(8'h85), 8'h13);
    rd("p1l", sfa(8'h84), 8'h00);
    wr(sfa(8'h92), 8'h00);
    `CHK("dptr0b", 16'h3231, active_dptr)
    stk_op <= MCSR_OP_PUSH;
    step(2);
    stk_op <= MCSR_OP_POP;
    step(1);
    stk_op <= MCSR_OP_NONE;
    step(2);
    `CHK("sp_push", 8'h31, sp_out)
    rd("sp", sfa(8'h81), 8'h31);
    wr(sfa(8'he0), 8'h07);
    `CHK("par", 8'h01, psw_out)
    for (int b = 0; b < 4; b++) begin
      wr(sfa(8'hd0), {3'b001, b[1:0], 3'b010});
      rd("psw", sfa(8'hd0), {3'b001, b[1:0], 3'b011});
      `CHK("bank", 5'(b * 8), bank_base)
    end
    wr(sfa(8'hd0), 8'h00);
    wr(sfa(8'he0), 8'h03);
    wr(sfa(8'hd0), 8'h01);
    rd("psw_par", sfa(8'hd0), 8'h00);
    flg_we <= 1'b1;
    {cy, nib, ov} <= 3'b110;
    step(1);
    {cy, nib, ov} <= 3'b001;
    step(1);
    flg_we <= 1'b0;
    step(1);
    `CHK("flags1", 8'hc0, psw_out)
    step(1);
    `CHK("flags2", 8'h04, psw_out)
    acc_we <= 1'b1;
    acc_wd <= 8'h80;
    b_we   <= 1'b1;
    b_wd   <= 8'hc3;
    step(1);
    {acc_we, b_we} <= 2'b00;
    step(2);
    `CHK("acc_dp", 8'h80, acc_out)
    `CHK("psw_dp", 8'h05, psw_out)
    rd("b_dp", sfa(8'hf0), 8'hc3);
    wr(sfa(8'h8e), 8'hff);
    rd("tim", sfa(8'h8e), 8'h77);
    `CHK("str_ff", 3'h7, external_data_space_stretch)
    `CHK("cw_ff", 3'h7, code_wait)
    wr(sfa(8'h8e), 8'h00);
    `CHK("str_00", 3'h0, external_data_space_stretch)
    wr(12'hc00, 8'h55);
    rd("unmap", 12'hc00, 8'h00);
    bus(1'b1, sfa(8'hf0), 8'h11, 4'he, q);
    rd("nosel", sfa(8'hf0), 8'hc3);
    wr(ira(8'h85), 8'h66);
    rd("ir_hi", ira(8'h85), 8'h66);
    iw(1'b0, 8'h85, 8'h99);
    `CHK("refuse", 1'b1, seen)
    rd("ir_kept", ira(8'h85), 8'h66);
    iw(1'b1, 8'h85, 8'h99);
    `CHK("ind_ok", 1'b0, seen)
    iw(1'b0, 8'h7f, 8'h42);
    `CHK("dir_ok", 1'b0, seen)
    rd("ir_lo", ira(8'h7f), 8'h42);
    ir_a <= 8'h85;
    step(3);
    `CHK("ir_rd", 8'h99, internal_scratch_memory_rdata)
    xw(16'h8000, 8'h5a);
    xw(16'h87ff, 8'ha5);
    xw(16'h8800, 8'h33);
    xw(16'h7fff, 8'h44);
    x_a <= 16'h8000;
    step(3);
    `CHK("xr_lo", 8'h5a, xram_rdata)
    `CHK("hit_lo", 1'b1, xram_hit)
    x_a <= 16'h87ff;
    step(3);
    `CHK("xr_hi", 8'ha5, xram_rdata)
    `CHK("hit_hi", 1'b1, xram_hit)
    x_a <= 16'h8800;
    step(3);
    `CHK("hit_out", 1'b0, xram_hit)
    tally_and_finish();
  end
endmodule : tb
